/* File: shared/skip_move_pkg.sv */
// Purpose: Constants and types shared by the skip-or-move datapath
// Assumes: One instruction presented per instruction cycle on mclk
// Notes:   Opcode codes are local to this block, not a machine encoding
package skip_move_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int FILE_DEPTH = 128;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic ZERO_RESET = 1'b0;
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;
  localparam int SKIP_CYCLES = 2;

  typedef enum logic [2:0] {
    nop_op,
    decrement_skip_zero_op,
    increment_skip_zero_op,
    or_literal_into_acc_op,
    load_literal_acc_op,
    or_acc_with_file_op,
    store_acc_to_file_op
  } op_e;
endpackage : skip_move_pkg

/* File: src/file_regs.sv */
// Purpose: File register array, one write port and one read port
// Assumes: Read is combinational, write on the clock edge
// Notes:   Contents are not reset, as in a real data memory
`timescale 1ns/100ps
module file_regs #(
  parameter int DEPTH = skip_move_pkg::FILE_DEPTH,
  parameter int AW    = skip_move_pkg::ADDR_W
) (
  input  wire logic          mclk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [7:0]    wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [7:0]    rd_data
);
  logic [7:0] mem [DEPTH];

  initial begin
    if (DEPTH > (1 << AW)) $error("Depth exceeds address range");
  end

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign rd_data = mem[rd_addr];
endmodule : file_regs

/* File: src/skip_or_move_instr_datapath.sv */
// Purpose: Executes six accumulator and file-register instructions
// Assumes: op_valid marks a new instruction each instruction cycle
// Notes:   Skip result squashes the following instruction
//
// Summary of operation
// - Decrement file, result to acc or file
// - Zero decrement result skips next instruction
// - Increment file, route by dest, no flags
// - Zero increment result skips next instruction
// - OR literal into acc, update zero
// - Load literal into acc, no flags
// - OR acc with file, route, update zero
// - Store acc into addressed file register
`timescale 1ns/100ps
module skip_or_move_instr_datapath #(
  parameter int AW = skip_move_pkg::ADDR_W
) (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              op_valid,
  input  skip_move_pkg::op_e     op,
  input  wire logic [AW-1:0]     file_addr,
  input  wire logic              dest,
  input  wire logic [7:0]        literal,
  output logic      [7:0]        acc,
  output logic                   zero_flag,
  output logic                   skip_active,
  output logic                   done,
  output logic                   file_wr,
  output logic      [AW-1:0]     file_wr_addr,
  output logic      [7:0]        file_wr_data
);
  typedef struct packed {
    logic [7:0]    acc;
    logic          zero_flag;
    logic          skip_active;
    logic          done;
    logic          file_wr;
    logic [AW-1:0] file_wr_addr;
    logic [7:0]    file_wr_data;
  } state_s;

  state_s st;
  state_s next_st;
  logic [7:0] file_rd;
  logic [7:0] result;
  logic       write_file;
  logic       write_acc;
  logic       touch_zero;
  logic       skip_req;
  logic       exec;

  initial begin
    if (AW != skip_move_pkg::ADDR_W) $error("Address width must be 7");
  end

  // Write lands on the edge, so a following read sees the new value
  file_regs #(.DEPTH(skip_move_pkg::FILE_DEPTH), .AW(AW)) u_regs (
    .mclk    (mclk),
    .wr_en   (next_st.file_wr),
    .wr_addr (next_st.file_wr_addr),
    .wr_data (next_st.file_wr_data),
    .rd_addr (file_addr),
    .rd_data (file_rd)
  );

  function automatic logic is_zero(input logic [7:0] v);
    return v == 8'h00;
  endfunction : is_zero

  // Instruction arriving during the skip cycle is discarded
  assign exec = op_valid && !st.skip_active;

  always_comb begin
    result     = 8'h00;
    write_file = 1'b0;
    write_acc  = 1'b0;
    touch_zero = 1'b0;
    skip_req   = 1'b0;
    case (op)
      skip_move_pkg::decrement_skip_zero_op: begin
        result     = file_rd - 8'h01;
        write_file = dest == skip_move_pkg::DEST_FILE;
        write_acc  = dest == skip_move_pkg::DEST_ACC;
        skip_req   = is_zero(result);
      end
      skip_move_pkg::increment_skip_zero_op: begin
        result     = file_rd + 8'h01;
        write_file = dest == skip_move_pkg::DEST_FILE;
        write_acc  = dest == skip_move_pkg::DEST_ACC;
        skip_req   = is_zero(result);
      end
      skip_move_pkg::or_literal_into_acc_op: begin
        result     = st.acc | literal;
        write_acc  = 1'b1;
        touch_zero = 1'b1;
      end
      skip_move_pkg::load_literal_acc_op: begin
        result    = literal;
        write_acc = 1'b1;
      end
      skip_move_pkg::or_acc_with_file_op: begin
        result     = st.acc | file_rd;
        write_file = dest == skip_move_pkg::DEST_FILE;
        write_acc  = dest == skip_move_pkg::DEST_ACC;
        touch_zero = 1'b1;
      end
      skip_move_pkg::store_acc_to_file_op: begin
        result     = st.acc;
        write_file = 1'b1;
      end
      default: begin
        result = 8'h00;
      end
    endcase
  end

  always_comb begin
    next_st              = st;
    next_st.file_wr      = 1'b0;
    next_st.done         = 1'b0;
    next_st.skip_active  = 1'b0;
    next_st.file_wr_addr = file_addr;
    next_st.file_wr_data = result;
    if (exec) begin
      next_st.done        = 1'b1;
      next_st.file_wr     = write_file;
      next_st.skip_active = skip_req;
      if (write_acc) begin
        next_st.acc = result;
      end
      if (touch_zero) begin
        next_st.zero_flag = is_zero(result);
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st <= '{acc: skip_move_pkg::ACC_RESET, zero_flag: skip_move_pkg::ZERO_RESET,
              default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign acc          = st.acc;
  assign zero_flag    = st.zero_flag;
  assign skip_active  = st.skip_active;
  assign done         = st.done;
  assign file_wr      = st.file_wr;
  assign file_wr_addr = st.file_wr_addr;
  assign file_wr_data = st.file_wr_data;

  sequence s_zero_skip;
    op_valid && !skip_active && op inside {skip_move_pkg::decrement_skip_zero_op,
      skip_move_pkg::increment_skip_zero_op} && is_zero(result);
  endsequence

  sequence s_skip_cycle;
    skip_active ##1 !skip_active;
  endsequence

  property p_skip_after_zero;
    @(posedge mclk) disable iff (rst) s_zero_skip |=> s_skip_cycle;
  endproperty
  a_skip_after_zero: assert property (p_skip_after_zero)
    else $error("Zero skip result did not squash one cycle");

  property p_no_done_in_skip;
    @(posedge mclk) disable iff (rst) skip_active |=> !done;
  endproperty
  a_no_done_in_skip: assert property (p_no_done_in_skip)
    else $error("Instruction executed during skip cycle");

  property p_dec_value;
    @(posedge mclk) disable iff (rst)
      exec && op == skip_move_pkg::decrement_skip_zero_op && !dest
      |=> acc == $past(file_rd) - 8'h01;
  endproperty
  a_dec_value: assert property (p_dec_value)
    else $error("Decrement result wrong");

  property p_inc_file;
    @(posedge mclk) disable iff (rst)
      exec && op == skip_move_pkg::increment_skip_zero_op && dest
      |=> file_wr && file_wr_data == $past(file_rd) + 8'h01 && $stable(zero_flag);
  endproperty
  a_inc_file: assert property (p_inc_file)
    else $error("Increment to file wrong or flag moved");

  property p_or_lit;
    @(posedge mclk) disable iff (rst)
      exec && op == skip_move_pkg::or_literal_into_acc_op
      |=> acc == ($past(acc) | $past(literal)) && zero_flag == (acc == 8'h00);
  endproperty
  a_or_lit: assert property (p_or_lit)
    else $error("Literal OR wrong");

  property p_load_lit;
    @(posedge mclk) disable iff (rst)
      exec && op == skip_move_pkg::load_literal_acc_op
      |=> acc == $past(literal) && $stable(zero_flag) && !file_wr;
  endproperty
  a_load_lit: assert property (p_load_lit)
    else $error("Literal load wrong");

  property p_or_file;
    @(posedge mclk) disable iff (rst)
      exec && op == skip_move_pkg::or_acc_with_file_op && dest
      |=> file_wr && file_wr_data == ($past(acc) | $past(file_rd))
          && zero_flag == (file_wr_data == 8'h00);
  endproperty
  a_or_file: assert property (p_or_file)
    else $error("File OR wrong");

  property p_store;
    @(posedge mclk) disable iff (rst)
      exec && op == skip_move_pkg::store_acc_to_file_op
      |=> file_wr && file_wr_addr == $past(file_addr) && file_wr_data == $past(acc)
          && $stable(zero_flag);
  endproperty
  a_store: assert property (p_store)
    else $error("Store to file wrong");

  // Skip forms leave every status flag alone, whatever the result
  property p_skip_no_flag;
    @(posedge mclk) disable iff (rst)
      exec && op inside {skip_move_pkg::decrement_skip_zero_op,
        skip_move_pkg::increment_skip_zero_op}
      |=> $stable(zero_flag);
  endproperty
  a_skip_no_flag: assert property (p_skip_no_flag)
    else $error("Skip instruction moved the zero flag");
endmodule : skip_or_move_instr_datapath

/* File: verif/tb_skip_or_move_instr_datapath.sv */
// Purpose: Self-checking bench for the skip-or-move datapath
// Assumes: Inputs move on the rising edge, outputs read 1 ns after it
// Notes:   File contents are seen only through acc and the write port
`timescale 1ns/100ps
module tb_skip_or_move_instr_datapath;
  typedef struct {
    skip_move_pkg::op_e op;
    logic [6:0]         a;
    logic               d;
    logic [7:0]         lit;
    logic [7:0]         acc;
    logic               z;
    logic               wr;
    logic [7:0]         wd;
    logic               sk;
  } row_s;
  localparam skip_move_pkg::op_e ld  = skip_move_pkg::load_literal_acc_op;
  localparam skip_move_pkg::op_e st  = skip_move_pkg::store_acc_to_file_op;
  localparam skip_move_pkg::op_e dsz = skip_move_pkg::decrement_skip_zero_op;
  localparam skip_move_pkg::op_e isz = skip_move_pkg::increment_skip_zero_op;
  localparam skip_move_pkg::op_e orl = skip_move_pkg::or_literal_into_acc_op;
  localparam skip_move_pkg::op_e orf = skip_move_pkg::or_acc_with_file_op;
  logic               mclk = 1'b0;
  logic               rst = 1'b1;
  logic               op_valid = 1'b0;
  skip_move_pkg::op_e op = skip_move_pkg::nop_op;
  logic [6:0]         file_addr = 7'h00;
  logic               dest = 1'b0;
  logic [7:0]         literal = 8'h00;
  logic [7:0]         acc;
  logic               zero_flag;
  logic               skip_active;
  logic               done;
  logic               file_wr;
  logic [6:0]         file_wr_addr;
  logic [7:0]         file_wr_data;
  int                 error_cnt = 0;
  int                 checks = 0;
  int                 cyc = 0;
  row_s               rows[16];

  skip_or_move_instr_datapath DUT (.mclk(mclk), .rst(rst), .op_valid(op_valid), .op(op),
    .file_addr(file_addr), .dest(dest), .literal(literal), .acc(acc), .zero_flag(zero_flag),
    .skip_active(skip_active), .done(done), .file_wr(file_wr), .file_wr_addr(file_wr_addr),
    .file_wr_data(file_wr_data));

  always #12.5 mclk = ~mclk;

  task automatic close_out();
    if (error_cnt == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out

  // Short run expected; ceiling leaves wide margin
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      close_out();
    end
  end

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk8

  task automatic drive(input skip_move_pkg::op_e o, input logic [6:0] a, input logic d,
                       input logic [7:0] k);
    @(posedge mclk);
    op_valid <= 1'b1;
    op <= o;
    file_addr <= a;
    dest <= d;
    literal <= k;
  endtask : drive

  initial begin
    // Ops chained so each leaves the state the next one reads
    rows = '{'{ld, 7'h00, 0, 8'h01, 8'h01, 0, 0, 8'h00, 0}, '{st, 7'h7F, 0, 8'h00, 8'h01, 0, 1, 8'h01, 0},
      '{dsz, 7'h7F, 0, 8'h00, 8'h00, 0, 0, 8'h00, 1}, '{dsz, 7'h7F, 1, 8'h00, 8'h00, 0, 1, 8'h00, 1},
      '{isz, 7'h7F, 0, 8'h00, 8'h01, 0, 0, 8'h00, 0}, '{ld, 7'h00, 0, 8'hFF, 8'hFF, 0, 0, 8'h00, 0},
      '{st, 7'h00, 0, 8'h00, 8'hFF, 0, 1, 8'hFF, 0}, '{isz, 7'h00, 1, 8'h00, 8'hFF, 0, 1, 8'h00, 1},
      '{ld, 7'h00, 0, 8'h00, 8'h00, 0, 0, 8'h00, 0}, '{orl, 7'h00, 0, 8'h00, 8'h00, 1, 0, 8'h00, 0},
      '{orl, 7'h00, 0, 8'hA5, 8'hA5, 0, 0, 8'h00, 0}, '{orf, 7'h00, 0, 8'h00, 8'hA5, 0, 0, 8'h00, 0},
      '{ld, 7'h00, 0, 8'h00, 8'h00, 0, 0, 8'h00, 0}, '{orf, 7'h7F, 1, 8'h00, 8'h00, 1, 1, 8'h00, 0},
      '{ld, 7'h00, 0, 8'h5A, 8'h5A, 1, 0, 8'h00, 0}, '{dsz, 7'h00, 0, 8'h00, 8'hFF, 1, 0, 8'h00, 0}};
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      drive(rows[i].op, rows[i].a, rows[i].d, rows[i].lit);
      @(posedge mclk);
      op_valid <= 1'b0;
      #1;
      chk8(acc, rows[i].acc);
      chk8({7'h00, zero_flag}, {7'h00, rows[i].z});
      chk8({7'h00, done}, 8'h01);
      chk8({7'h00, file_wr}, {7'h00, rows[i].wr});
      if (rows[i].wr) begin
        chk8(file_wr_data, rows[i].wd);
        chk8({1'b0, file_wr_addr}, {1'b0, rows[i].a});
      end
      chk8({7'h00, skip_active}, {7'h00, rows[i].sk});
      @(posedge mclk);
    end
    // Back to back: op after a zero skip is dropped, the one after it runs
    drive(ld, 7'h00, 0, 8'h01);
    drive(st, 7'h05, 0, 8'h00);
    drive(dsz, 7'h05, 0, 8'h00);
    drive(ld, 7'h00, 0, 8'h77);
    #1;
    chk8({7'h00, skip_active}, 8'h01);
    chk8(acc, 8'h00);
    drive(ld, 7'h00, 0, 8'h33);
    #1;
    chk8({7'h00, done}, 8'h00);
    chk8(acc, 8'h00);
    @(posedge mclk);
    op_valid <= 1'b0;
    #1;
    chk8(acc, 8'h33);
    chk8({7'h00, done}, 8'h01);
    // Reset in mid-run clears acc and flag
    drive(orl, 7'h00, 0, 8'h00);
    rst <= 1'b1;
    #1;
    chk8({zero_flag, done, file_wr, skip_active, 4'h0}, 8'h00);
    chk8(acc, 8'h00);
    // Release again; first op after release must run, nop only completes
    @(posedge mclk);
    rst <= 1'b0;
    op_valid <= 1'b0;
    drive(orl, 7'h00, 0, 8'h00);
    drive(skip_move_pkg::nop_op, 7'h00, 1, 8'hFF);
    #1;
    chk8({6'h00, zero_flag, done}, 8'h03);
    @(posedge mclk);
    op_valid <= 1'b0;
    #1;
    chk8({6'h00, file_wr, done}, 8'h01);
    chk8({7'h00, zero_flag}, 8'h01);
    chk8(acc, 8'h00);
    close_out();
  end
endmodule : tb_skip_or_move_instr_datapath
